// >>> src/pcir_pkg.sv
`default_nettype none
package pcir_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_BANK_SEL = 4'he;
  localparam logic [3:0] IDX_GCC      = 4'ha;
  localparam logic [3:0] IDX_IAC      = 4'h0;
  localparam logic [3:0] IDX_IDAT_RA  = 4'h2;
  localparam logic [3:0] IDX_IDAT_RB  = 4'h4;
  localparam logic [3:0] IDX_IDAT_RC  = 4'h6;
  localparam logic [3:0] IDX_IDAT_LO  = 4'h8;
  localparam logic [3:0] IDX_IDAT_HI  = 4'ha;
  localparam logic [3:0] IDX_PBC      = 4'h0;
  localparam logic [3:0] IDX_PORT_A   = 4'h2;
  localparam logic [3:0] IDX_PORT_B   = 4'h4;

  localparam int unsigned BANK_W = 6;
  localparam logic [5:0] BANK_GLOBAL   = 6'h20;
  localparam logic [5:0] BANK_INDIRECT = 6'h2a;
  localparam logic [5:0] BANK_PHY      = 6'h2d;
  localparam logic [5:0] BANK_PORT     = 6'h31;

  localparam logic [5:0]  BANK_RST  = 6'h00;
  localparam logic [15:0] GCC_RST   = 16'h0835;
  localparam logic [15:0] IAC_RST   = 16'h0000;
  localparam logic [15:0] IDAT_RST  = 16'h0000;
  localparam logic [15:0] PBC_RST   = 16'h1020;
  localparam logic [15:0] PBC_WMASK = 16'h7b3f;

  localparam int unsigned LED_HI_BIT = 15;
  localparam int unsigned LED_LO_BIT = 9;

  localparam int unsigned IAC_DIR_BIT = 12;
  localparam int unsigned IAC_TSEL_HI = 11;
  localparam int unsigned IAC_TSEL_LO = 10;
  localparam int unsigned IAC_ADDR_HI = 9;
  localparam logic [1:0]  TSEL_MIB    = 2'h3;

  localparam int unsigned BC_FORCE100 = 13;
  localparam int unsigned BC_AN_EN    = 12;
  localparam int unsigned BC_PDOWN    = 11;
  localparam int unsigned BC_RESTART  = 9;
  localparam int unsigned BC_FULL     = 8;
  localparam int unsigned BC_XSTYLE   = 5;
  localparam int unsigned BC_FMDIX    = 4;
  localparam int unsigned BC_DMDIX    = 3;
  localparam int unsigned BC_RSV2     = 2;
  localparam int unsigned BC_TXDIS    = 1;
  localparam int unsigned BC_LEDDIS   = 0;

  // mirror positions in the port control words
  localparam int unsigned MAP_N = 10;
  localparam int unsigned MAP_BC [MAP_N] = '{BC_FORCE100, BC_AN_EN, BC_PDOWN,
    BC_RESTART, BC_FULL, BC_FMDIX, BC_DMDIX, BC_RSV2, BC_TXDIS, BC_LEDDIS};
  localparam int unsigned MAP_PA [MAP_N] = '{6, 7, 11, 13, 5, 9, 10, 12, 14, 15};
  localparam int unsigned PB_XSTYLE = 15;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned MIB_DEPTH = 32;
  localparam int unsigned MIB_AW    = 5;

  typedef struct packed {
    logic link_up;
    logic activity;
    logic full_duplex;
    logic collision;
    logic speed_100;
    logic an_failed;
  } pcir_link_stat_t;

  typedef struct packed {
    logic port_lamp_three;
    logic port_lamp_two;
    logic port_lamp_one;
    logic port_lamp_zero;
  } pcir_lamp_t;

  typedef struct packed {
    logic an_enable;
    logic force_100;
    logic force_full;
    logic power_down;
    logic restart_an;
    logic crossover_style_select;
    logic force_mdix;
    logic disable_mdix;
    logic tx_disable;
    logic lamp_disable;
  } pcir_phy_ctl_t;

  typedef struct packed {
    logic            aw_held;
    logic [3:0]      aw_idx;
    logic            aw_bad;
    logic            awready;
    logic            w_held;
    logic [15:0]     w_data;
    logic [1:0]      w_strb;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [15:0]     rdata;
    logic [1:0]      rresp;
    logic [5:0]      bank;
    logic [15:0]     gcc;
    logic [15:0]     iac;
    logic [15:0]     idat_lo;
    logic [15:0]     idat_hi;
    logic [15:0]     pbc;
    logic            mib_go;
    pcir_link_stat_t sync1;
    pcir_link_stat_t sync2;
    pcir_lamp_t      lamps;
    pcir_phy_ctl_t   phy;
  } pcir_state_t;

  typedef struct packed {
    logic [MIB_DEPTH-1:0][31:0] ent;
  } pcir_mib_state_t;

endpackage
`default_nettype wire

// >>> src/pcir_mib_store.sv
`default_nettype none
module pcir_mib_store
  import pcir_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        wr_en,
  input  wire logic [9:0]  addr,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata
);

  pcir_mib_state_t st_ff;
  pcir_mib_state_t nxt_st;
  logic            in_range;

  // entries beyond the store read zero and drop writes
  always_comb begin
    in_range = (addr < 10'(MIB_DEPTH));
    nxt_st   = st_ff;
    rdata    = 32'h0;
    if (in_range) begin
      rdata = st_ff.ent[addr[MIB_AW-1:0]];
      if (wr_en) begin
        nxt_st.ent[addr[MIB_AW-1:0]] = wdata;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule
`default_nettype wire

// >>> src/pcir_regs.sv
// The AXI4-Lite register port is this design's own decision.
`default_nettype none
// Notes on behaviour
// - led mode picks lamp roles; mode 11 and unlisted lamps stay dark
// - led mode high bit 15, low bit 9 of global control, reset zero
// - each indirect control write with a byte strobe set and table code 11 starts one indirect command
// - indirect control bit 12: one reads the entry, zero writes it
// - only table code 11 selects counters; other codes do nothing
// - entry address comes from indirect control bits 9 to 0
// - low data word at index 8 holds data bits 15 to 0
// - high data word at index 0x0a holds data bits 31 to 16
// - bank select at index 0x0e works in every bank
// - basic control bit 12 enables auto-negotiation, resets to one
// - with negotiation off, bit 13 forces 100 or 10 mbit/s
// - bit 8 forces duplex when negotiation off or failed
// - bit 11 powers the phy down while set
// - bit 9 set by host restarts auto-negotiation
// - bit 5 picks crossover style, one by default
// - bit 4 forces crossed pair assignment
// - bit 3 disables automatic crossover detection
// - bit 1 suppresses phy transmission
// - bit 0 turns all port lamps off
// - soft reset, isolate, collision test bits read zero
// - basic control bits share storage with port control words
module pcir_regs
  import pcir_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      awaddr,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  input  wire logic [7:0]      araddr,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  input  wire pcir_link_stat_t link_in,
  output pcir_lamp_t           lamp_out,
  output pcir_phy_ctl_t        phy_out
);

  pcir_state_t st_ff;
  pcir_state_t nxt_st;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        wr_fire;
  logic [15:0] wd;
  logic [1:0]  ws;
  logic        mib_we;
  logic [31:0] mib_rdata;
  logic        la;
  logic [1:0]  led_mode;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] r;
    r = old;
    for (int b = 0; b < 2; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = (nw[b*8 +: 8] & mask[b*8 +: 8]) | (old[b*8 +: 8] & ~mask[b*8 +: 8]);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] rd_word(input pcir_state_t s, input logic [3:0] idx);
    logic [15:0] r;
    r = 16'h0;
    if (idx == IDX_BANK_SEL) begin
      r[BANK_W-1:0] = s.bank;
    end else begin
      case (s.bank)
        BANK_GLOBAL: begin
          if (idx == IDX_GCC) r = s.gcc;
        end
        BANK_INDIRECT: begin
          if (idx == IDX_IAC) r = s.iac;
          if (idx == IDX_IDAT_LO) r = s.idat_lo;
          if (idx == IDX_IDAT_HI) r = s.idat_hi;
        end
        BANK_PHY: begin
          if (idx == IDX_PBC) r = s.pbc & PBC_WMASK;
        end
        BANK_PORT: begin
          if (idx == IDX_PORT_A) begin
            for (int i = 0; i < MAP_N; i++) r[MAP_PA[i]] = s.pbc[MAP_BC[i]];
          end
          if (idx == IDX_PORT_B) r[PB_XSTYLE] = s.pbc[BC_XSTYLE];
        end
        default: r = 16'h0;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    nxt_st   = st_ff;
    aw_take  = awvalid & st_ff.awready;
    w_take   = wvalid & st_ff.wready;
    ar_take  = arvalid & st_ff.arready;
    wr_fire  = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;
    wd       = st_ff.w_data;
    ws       = st_ff.w_strb;
    led_mode = {st_ff.gcc[LED_HI_BIT], st_ff.gcc[LED_LO_BIT]};
    la       = st_ff.sync2.link_up & ~st_ff.sync2.activity;

    nxt_st.sync1  = link_in;
    nxt_st.sync2  = st_ff.sync1;
    nxt_st.mib_go = 1'b0;

    // a counter read lands in both data words one cycle after the command
    if (st_ff.mib_go && st_ff.iac[IAC_DIR_BIT]) begin
      nxt_st.idat_lo = mib_rdata[15:0];
      nxt_st.idat_hi = mib_rdata[31:16];
    end

    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (aw_take) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_idx  = awaddr[5:2];
      nxt_st.aw_bad  = |awaddr[7:6];
    end
    if (w_take) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = wdata[15:0];
      nxt_st.w_strb = wstrb[1:0];
    end

    if (wr_fire) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = st_ff.aw_bad ? RESP_SLVERR : RESP_OKAY;
      if (!st_ff.aw_bad) begin
        if (st_ff.aw_idx == IDX_BANK_SEL) begin
          if (ws[0]) nxt_st.bank = wd[BANK_W-1:0];
        end else begin
          case (st_ff.bank)
            BANK_GLOBAL: begin
              if (st_ff.aw_idx == IDX_GCC) nxt_st.gcc = merge16(st_ff.gcc, wd, ws, 16'hffff);
            end
            BANK_INDIRECT: begin
              if (st_ff.aw_idx == IDX_IAC && |ws) begin
                nxt_st.iac    = merge16(st_ff.iac, wd, ws, 16'hffff);
                nxt_st.mib_go = (nxt_st.iac[IAC_TSEL_HI:IAC_TSEL_LO] == TSEL_MIB);
              end
              if (st_ff.aw_idx == IDX_IDAT_LO) nxt_st.idat_lo = merge16(nxt_st.idat_lo, wd, ws, 16'hffff);
              if (st_ff.aw_idx == IDX_IDAT_HI) nxt_st.idat_hi = merge16(nxt_st.idat_hi, wd, ws, 16'hffff);
            end
            BANK_PHY: begin
              if (st_ff.aw_idx == IDX_PBC) nxt_st.pbc = merge16(st_ff.pbc, wd, ws, PBC_WMASK);
            end
            BANK_PORT: begin
              if (st_ff.aw_idx == IDX_PORT_A) begin
                for (int i = 0; i < MAP_N; i++) begin
                  if (ws[MAP_PA[i] / 8]) nxt_st.pbc[MAP_BC[i]] = wd[MAP_PA[i]];
                end
              end
              if (st_ff.aw_idx == IDX_PORT_B && ws[1]) nxt_st.pbc[BC_XSTYLE] = wd[PB_XSTYLE];
            end
            default: nxt_st.bank = st_ff.bank;
          endcase
        end
      end
    end
    nxt_st.awready = ~nxt_st.aw_held;
    nxt_st.wready  = ~nxt_st.w_held;

    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = (|araddr[7:6]) ? RESP_SLVERR : RESP_OKAY;
      nxt_st.rdata  = (|araddr[7:6]) ? 16'h0 : rd_word(st_ff, araddr[5:2]);
    end
    nxt_st.arready = ~nxt_st.rvalid;

    // lamp roles by mode, all dark when disabled
    nxt_st.lamps = '0;
    if (!st_ff.pbc[BC_LEDDIS]) begin
      case (led_mode)
        2'h0: begin
          nxt_st.lamps.port_lamp_two  = la;
          nxt_st.lamps.port_lamp_one  = st_ff.sync2.full_duplex | st_ff.sync2.collision;
          nxt_st.lamps.port_lamp_zero = st_ff.sync2.speed_100;
        end
        2'h1: begin
          nxt_st.lamps.port_lamp_two  = la & st_ff.sync2.speed_100;
          nxt_st.lamps.port_lamp_one  = la & ~st_ff.sync2.speed_100;
          nxt_st.lamps.port_lamp_zero = st_ff.sync2.full_duplex;
        end
        2'h2: begin
          nxt_st.lamps.port_lamp_three = st_ff.sync2.activity;
          nxt_st.lamps.port_lamp_two   = st_ff.sync2.link_up;
          nxt_st.lamps.port_lamp_one   = st_ff.sync2.full_duplex | st_ff.sync2.collision;
          nxt_st.lamps.port_lamp_zero  = st_ff.sync2.speed_100;
        end
        default: nxt_st.lamps = '0;
      endcase
    end

    nxt_st.phy.an_enable  = st_ff.pbc[BC_AN_EN];
    nxt_st.phy.force_100  = st_ff.pbc[BC_FORCE100] & ~st_ff.pbc[BC_AN_EN];
    nxt_st.phy.force_full = st_ff.pbc[BC_FULL]
                          & (~st_ff.pbc[BC_AN_EN] | st_ff.sync2.an_failed);
    nxt_st.phy.power_down             = st_ff.pbc[BC_PDOWN];
    nxt_st.phy.restart_an             = st_ff.pbc[BC_RESTART];
    nxt_st.phy.crossover_style_select = st_ff.pbc[BC_XSTYLE];
    nxt_st.phy.force_mdix             = st_ff.pbc[BC_FMDIX];
    nxt_st.phy.disable_mdix           = st_ff.pbc[BC_DMDIX];
    nxt_st.phy.tx_disable             = st_ff.pbc[BC_TXDIS];
    nxt_st.phy.lamp_disable           = st_ff.pbc[BC_LEDDIS];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff         <= '0;
      st_ff.awready <= 1'b1;
      st_ff.wready  <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.bank    <= BANK_RST;
      st_ff.gcc     <= GCC_RST;
      st_ff.iac     <= IAC_RST;
      st_ff.idat_lo <= IDAT_RST;
      st_ff.idat_hi <= IDAT_RST;
      st_ff.pbc     <= PBC_RST;
      st_ff.phy.an_enable <= 1'b1;
      st_ff.phy.crossover_style_select <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mib_we = st_ff.mib_go & ~st_ff.iac[IAC_DIR_BIT];

  pcir_mib_store u_mib (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (mib_we),
    .addr    (st_ff.iac[IAC_ADDR_HI:0]),
    .wdata   ({st_ff.idat_hi, st_ff.idat_lo}),
    .rdata   (mib_rdata)
  );

  assign awready  = st_ff.awready;
  assign wready   = st_ff.wready;
  assign bvalid   = st_ff.bvalid;
  assign bresp    = st_ff.bresp;
  assign arready  = st_ff.arready;
  assign rvalid   = st_ff.rvalid;
  assign rresp    = st_ff.rresp;
  assign rdata    = {16'h0, st_ff.rdata};
  assign lamp_out = st_ff.lamps;
  assign phy_out  = st_ff.phy;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic iac_wr;
  assign iac_wr = wr_fire & ~st_ff.aw_bad & (st_ff.bank == BANK_INDIRECT)
                & (st_ff.aw_idx == IDX_IAC) & (|ws);

  property p_lamp_mode_two;
    (led_mode == 2'h2 && !st_ff.pbc[BC_LEDDIS])
      |=> lamp_out.port_lamp_three == $past(st_ff.sync2.activity);
  endproperty
  a_lamp_mode_two: assert property (p_lamp_mode_two) else $error("lamp three wrong");

  property p_lamp_off;
    st_ff.pbc[BC_LEDDIS] |=> lamp_out == '0;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamps lit while off");

  property p_led_mode_write;
    (wr_fire && !st_ff.aw_bad && st_ff.bank == BANK_GLOBAL && st_ff.aw_idx == IDX_GCC
     && ws == 2'h3) |=> led_mode == {$past(wd[LED_HI_BIT]), $past(wd[LED_LO_BIT])};
  endproperty
  a_led_mode_write: assert property (p_led_mode_write) else $error("led mode lost");

  sequence s_mib_write;
    mib_we ##1 !mib_we;
  endsequence
  property p_cmd_write;
    (iac_wr && wd[IAC_TSEL_HI:IAC_TSEL_LO] == TSEL_MIB && ws == 2'h3 && !wd[IAC_DIR_BIT])
      |=> s_mib_write;
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("write command lost");

  property p_reserved_table;
    (iac_wr && ws == 2'h3 && wd[IAC_TSEL_HI:IAC_TSEL_LO] != TSEL_MIB) |=> !st_ff.mib_go;
  endproperty
  a_reserved_table: assert property (p_reserved_table) else $error("reserved table ran");

  property p_read_low;
    (st_ff.mib_go && st_ff.iac[IAC_DIR_BIT]) |=> st_ff.idat_lo == $past(mib_rdata[15:0]);
  endproperty
  a_read_low: assert property (p_read_low) else $error("low word not loaded");

  property p_read_high;
    (st_ff.mib_go && st_ff.iac[IAC_DIR_BIT]) |=> st_ff.idat_hi == $past(mib_rdata[31:16]);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high word not loaded");

  property p_bank_sel_read;
    (ar_take && araddr == {2'h0, IDX_BANK_SEL, 2'h0})
      |=> rvalid && rdata[BANK_W-1:0] == $past(st_ff.bank);
  endproperty
  a_bank_sel_read: assert property (p_bank_sel_read) else $error("bank select unreadable");

  property p_force_speed;
    (st_ff.pbc[BC_FORCE100] && !st_ff.pbc[BC_AN_EN]) |=> phy_out.force_100 && !phy_out.an_enable;
  endproperty
  a_force_speed: assert property (p_force_speed) else $error("speed not forced");

  property p_mirror;
    (wr_fire && !st_ff.aw_bad && st_ff.bank == BANK_PORT && st_ff.aw_idx == IDX_PORT_A && ws[0])
      |=> st_ff.pbc[BC_AN_EN] == $past(wd[7]) ##1 phy_out.an_enable == $past(wd[7], 2);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror write lost");

  property p_duplex_force;
    (st_ff.pbc[BC_FULL] && st_ff.sync2.an_failed) |=> phy_out.force_full;
  endproperty
  a_duplex_force: assert property (p_duplex_force) else $error("duplex not forced");

  property p_rsv_zero;
    (ar_take && araddr == {2'h0, IDX_PBC, 2'h0} && st_ff.bank == BANK_PHY)
      |=> rdata[15] == 1'b0 && rdata[10] == 1'b0 && rdata[7] == 1'b0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("unsupported bit set");

endmodule
`default_nettype wire

// >>> sim/pcir_link_model.sv
`default_nettype none
module pcir_link_model
  import pcir_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic [1:0] scene,
  output pcir_link_stat_t link
);
  timeunit 1ns;
  timeprecision 1ps;

  // phy side level sets: link, activity, duplex, collision, speed, an fail
  localparam logic [5:0] SCENE [4] = '{6'h2a, 6'h24, 6'h10, 6'h2b};

  // levels change only just after a clock edge
  always_ff @(posedge aclk) begin
    link <= pcir_link_stat_t'(SCENE[scene]);
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`default_nettype none
module testbench
  import pcir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic            aclk;
  logic            aresetn;
  logic [7:0]      awaddr;
  logic            awvalid;
  logic            awready;
  logic [31:0]     wdata;
  logic [3:0]      wstrb;
  logic            wvalid;
  logic            wready;
  logic [1:0]      bresp;
  logic            bvalid;
  logic            bready;
  logic [7:0]      araddr;
  logic            arvalid;
  logic            arready;
  logic [31:0]     rdata;
  logic [1:0]      rresp;
  logic            rvalid;
  logic            rready;
  logic [1:0]      scene;
  pcir_link_stat_t link_in;
  pcir_lamp_t      lamp_out;
  pcir_phy_ctl_t   phy_out;
  int              n_errors = 0;
  int              n_tests = 0;

  pcir_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link_in(link_in), .lamp_out(lamp_out), .phy_out(phy_out));

  pcir_link_model link_mdl (.aclk(aclk), .scene(scene), .link(link_in));

  always #2 aclk = ~aclk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic timeout();
    n_errors++;
    $display("CHECK FAILED bus answer expected within 50 cycles seen none");
    test_done();
  endtask

  function automatic logic [7:0] ad(input logic [3:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int   k;
    logic aw;
    logic w;
    k = 0;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw || w) && k < 50) begin
      @(posedge aclk);
      k++;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      k++;
    end while (bvalid !== 1'b1 && k < 50);
    bready <= 1'b0;
    if (k >= 50) timeout();
    chk("write response", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rdc(input logic [7:0] a, input string nm, input logic [15:0] e,
                     input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (arready !== 1'b1 && k < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      k++;
    end while (rvalid !== 1'b1 && k < 50);
    rready <= 1'b0;
    if (k >= 50) timeout();
    chk(nm, rdata, {16'h0000, e});
    chk("read response", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic bank(input logic [5:0] b);
    wr(ad(IDX_BANK_SEL), {10'h000, b}, RESP_OKAY);
  endtask

  task automatic go_scene(input logic [1:0] s);
    @(posedge aclk);
    scene <= s;
    repeat (6) @(posedge aclk);
  endtask

  function automatic logic [3:0] elamp(input logic [1:0] m, input pcir_link_stat_t s);
    logic la;
    la = s.link_up & ~s.activity;
    case (m)
      2'b00: return {1'b0, la, s.full_duplex | s.collision, s.speed_100};
      2'b01: return {1'b0, la & s.speed_100, la & ~s.speed_100, s.full_duplex};
      2'b10: return {s.activity, s.link_up, s.full_duplex | s.collision, s.speed_100};
      default: return 4'h0;
    endcase
  endfunction

  function automatic pcir_phy_ctl_t ephy(input logic [15:0] v, input logic anf);
    return '{v[12], v[13] & ~v[12], v[8] & (~v[12] | anf), v[11], v[9], v[5], v[4],
             v[3], v[1], v[0]};
  endfunction

  function automatic logic [15:0] epa(input logic [15:0] v);
    epa = 16'h0000;
    for (int i = 0; i < MAP_N; i++) epa[MAP_PA[i]] = v[MAP_BC[i]];
  endfunction

  task automatic t_reset();
    rdc(ad(IDX_BANK_SEL), "bank select", 16'h0000, RESP_OKAY);
    bank(BANK_GLOBAL);
    rdc(ad(IDX_GCC), "global control", 16'h0835, RESP_OKAY);
    bank(BANK_PHY);
    rdc(ad(IDX_PBC), "basic control", 16'h1020, RESP_OKAY);
    $display("test reset values done");
  endtask

  task automatic t_led();
    logic [15:0] v;
    bank(BANK_GLOBAL);
    for (int m = 0; m < 4; m++) begin
      v = 16'h0835 | (16'(m >> 1) << 15) | (16'(m & 1) << 9);
      wr(ad(IDX_GCC), v, RESP_OKAY);
      rdc(ad(IDX_GCC), "global control", v, RESP_OKAY);
      for (int s = 0; s < 4; s++) begin
        go_scene(2'(s));
        chk("lamps", 32'(lamp_out), 32'(elamp(2'(m), link_in)));
      end
    end
    wr(ad(IDX_GCC), 16'h0835, RESP_OKAY);
    $display("test lamp modes done");
  endtask

  task automatic t_phy();
    logic [15:0] vals [3];
    vals = '{16'h2100, 16'h0000, 16'h1100};
    bank(BANK_PHY);
    wr(ad(IDX_PBC), 16'hffff, RESP_OKAY);
    rdc(ad(IDX_PBC), "basic control", 16'h7b3f, RESP_OKAY);
    go_scene(2'h3);
    chk("phy controls", 32'(phy_out), 32'(ephy(16'h7b3f, 1'b1)));
    chk("lamps disabled", 32'(lamp_out), 32'h0);
    bank(BANK_PORT);
    rdc(ad(IDX_PORT_A), "port control a", epa(16'h7b3f), RESP_OKAY);
    rdc(ad(IDX_PORT_B), "port control b", 16'h8000, RESP_OKAY);
    wr(ad(IDX_PORT_A), 16'h0000, RESP_OKAY);
    wr(ad(IDX_PORT_B), 16'h0000, RESP_OKAY);
    bank(BANK_PHY);
    rdc(ad(IDX_PBC), "basic control", 16'h4000, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wr(ad(IDX_PBC), vals[i], RESP_OKAY);
      for (int s = 0; s < 4; s += 3) begin
        go_scene(2'(s));
        chk("phy controls", 32'(phy_out), 32'(ephy(vals[i], link_in.an_failed)));
      end
    end
    $display("test phy control done");
  endtask

  task automatic t_ind();
    bank(BANK_INDIRECT);
    rdc(ad(IDX_BANK_SEL), "bank select", 16'h002a, RESP_OKAY);
    wr(ad(IDX_IDAT_LO), 16'h1234, RESP_OKAY);
    wr(ad(IDX_IDAT_HI), 16'habcd, RESP_OKAY);
    wr(ad(IDX_IAC), 16'h0c05, RESP_OKAY);
    wr(ad(IDX_IDAT_LO), 16'hffff, RESP_OKAY);
    wr(ad(IDX_IDAT_HI), 16'hffff, RESP_OKAY);
    wr(ad(IDX_IAC), 16'h1c06, RESP_OKAY);
    rdc(ad(IDX_IDAT_LO), "data low", 16'h0000, RESP_OKAY);
    wr(ad(IDX_IAC), 16'h1c05, RESP_OKAY);
    rdc(ad(IDX_IDAT_LO), "data low", 16'h1234, RESP_OKAY);
    rdc(ad(IDX_IDAT_HI), "data high", 16'habcd, RESP_OKAY);
    rdc(ad(IDX_IDAT_RA), "reserved data", 16'h0000, RESP_OKAY);
    wr(ad(IDX_IDAT_LO), 16'h5555, RESP_OKAY);
    wr(ad(IDX_IAC), 16'h0c05, RESP_OKAY);
    for (int t = 0; t < 3; t++) begin
      wr(ad(IDX_IDAT_LO), 16'h0f0f, RESP_OKAY);
      wr(ad(IDX_IAC), {4'b0001, 2'(t), 10'h005}, RESP_OKAY);
      rdc(ad(IDX_IDAT_LO), "data low", 16'h0f0f, RESP_OKAY);
      wr(ad(IDX_IAC), {4'b0000, 2'(t), 10'h005}, RESP_OKAY);
    end
    wr(ad(IDX_IAC), 16'h1c05, RESP_OKAY);
    rdc(ad(IDX_IDAT_LO), "data low", 16'h5555, RESP_OKAY);
    wr(8'h40, 16'h0001, RESP_SLVERR);
    rdc(8'h80, "unmapped read", 16'h0000, RESP_SLVERR);
    bank(6'h21);
    rdc(ad(IDX_GCC), "reserved bank", 16'h0000, RESP_OKAY);
    rdc(ad(IDX_BANK_SEL), "bank select", 16'h0021, RESP_OKAY);
    $display("test indirect access done");
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    scene = 2'h0;
    repeat (5) @(posedge aclk);
    chk("lamps in reset", 32'(lamp_out), 32'h0);
    chk("phy in reset", 32'(phy_out), 32'(ephy(16'h1020, 1'b0)));
    @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_led();
    t_phy();
    t_ind();
    test_done();
  end
endmodule
`default_nettype wire
